// [hdl/usb_interrupt_flag_register.v]
// USB interrupt flag register with APB slave, bus timers, error gating and token status queue.
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "usb_flags_defines.vh"

//////////////////////////////////////////////////////////////////////////////
// Operation
// - Flag register 8 bits, upper bits read zero
// - Hardware sets flags, software writes one clears
// - Stall flag on received or sent STALL
// - Attach flag when peripheral attach detected
// - Attach needs host mode, 2.5us quiet, not SE0
// - Resume flag after 2.5us K-state
// - Idle flag after 3 ms continuous idle
// - Token flag when token done, status readable
// - Clearing token flag advances status queue
// - SOF flag: device token or host threshold
// - Error flag only from enabled errors
// - Device mode: bit 0 is bus reset
// - Host mode: bit 0 is detach
module usb_interrupt_flag_register #(
  parameter IDLE_CYCLES = `IDLE_CYCLES_DEFAULT,
  parameter ERR_WIDTH = 8,
  parameter STAT_WIDTH = 8,
  parameter STAT_DEPTH_LOG2 = 2
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg irq,
  output reg host_operation_enable,
  input wire stall_event,
  input wire bus_activity,
  input wire bus_se0,
  input wire bus_k_state,
  input wire bus_idle_state,
  input wire peer_present,
  input wire token_done,
  input wire [STAT_WIDTH-1:0] token_status,
  input wire sof_token_rx,
  input wire sof_threshold_hit,
  input wire [ERR_WIDTH-1:0] error_events,
  input wire bus_reset_detect
);
  localparam QUIET_W = 9;
  localparam IDLE_W = 24;
  // The timing counts are held as integers and then cut to their counter width on purpose.
  // Both fit with room to spare, so the cut drops only leading zeros.
  localparam integer QUIET_COUNT = `QUIET_CYCLES;
  localparam integer IDLE_COUNT = IDLE_CYCLES;
  localparam [QUIET_W-1:0] QUIET_LIMIT = QUIET_COUNT[QUIET_W-1:0];
  localparam [IDLE_W-1:0] IDLE_LIMIT = IDLE_COUNT[IDLE_W-1:0];

  reg [7:0] usb_interrupt_flags_reg;
  reg [7:0] usb_interrupt_flags_next;
  reg [7:0] irq_mask_reg;
  reg [ERR_WIDTH-1:0] error_interrupt_enable_reg;
  reg [ERR_WIDTH-1:0] error_status_reg;
  reg [QUIET_W-1:0] quiet_cnt_reg;
  reg [QUIET_W-1:0] kstate_cnt_reg;
  reg [IDLE_W-1:0] idle_cnt_reg;
  reg peer_seen_reg;
  reg [7:0] events;
  reg [31:0] rd_mux;
  wire [STAT_WIDTH-1:0] token_status_reg;
  wire stat_empty;
  wire stat_full;
  reg [STAT_DEPTH_LOG2:0] stat_count_reg;
  wire stat_push_ok;
  wire stat_pop_ok;
  wire stat_more_after_pop;
  wire [IDLE_W-1:0] quiet_step;
  wire [IDLE_W-1:0] kstate_step;
  wire [IDLE_W-1:0] idle_step;
  wire wr_access;
  wire [7:0] clear_bits;
  wire quiet_done;
  wire token_pop;

  // Saturating counter step, shared by the bus timers.
  function [IDLE_W-1:0] sat_step;
    input [IDLE_W-1:0] cnt;
    input [IDLE_W-1:0] limit;
    input run;
    begin
      if (!run) begin
        sat_step = {IDLE_W{1'b0}};
      end else if (cnt >= limit) begin
        sat_step = limit;
      end else begin
        sat_step = cnt + 1'b1;
      end
    end
  endfunction

  // True when the address selects a mapped register.
  function mapped;
    input [11:0] addr;
    begin
      mapped = (addr == `OFS_FLAGS) || (addr == `OFS_IRQ_MASK) || (addr == `OFS_ERR_ENABLE) ||
        (addr == `OFS_ERR_STATUS) || (addr == `OFS_CONTROL) || (addr == `OFS_TOKEN_STATUS);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // APB access decode; the slave answers on the first access cycle.
  // A write lands only at the edge that completes the access, with pready high.
  // Holding penable longer than the protocol allows therefore cannot clear a flag twice.
  assign wr_access = psel && penable && pready && pwrite && mapped(paddr);
  // Flags clear only on ones written.
  assign clear_bits = (wr_access && paddr == `OFS_FLAGS) ? pwdata[7:0] : 8'h00;
  // Queue pops only when software clears a flag that is actually set.
  assign token_pop = clear_bits[`BIT_TOKEN] && usb_interrupt_flags_reg[`BIT_TOKEN];

  // Queue fill level as the queue itself sees it: a push into a full queue and a pop from an empty one do nothing.
  // Keeping the level here lets the token flag stay up while results remain queued.
  assign stat_push_ok = token_done && !stat_full;
  assign stat_pop_ok = token_pop && !stat_empty;
  assign stat_more_after_pop = (stat_count_reg > {{STAT_DEPTH_LOG2{1'b0}}, 1'b1});

  // Next counts of the three timers; the short ones use the wide function and are cut back to their width.
  // The counters saturate, so a long quiet or idle stretch never wraps and fires a second time.
  assign quiet_step = sat_step({{(IDLE_W-QUIET_W){1'b0}}, quiet_cnt_reg},
    {{(IDLE_W-QUIET_W){1'b0}}, QUIET_LIMIT}, !bus_activity);
  assign kstate_step = sat_step({{(IDLE_W-QUIET_W){1'b0}}, kstate_cnt_reg},
    {{(IDLE_W-QUIET_W){1'b0}}, QUIET_LIMIT}, bus_k_state);
  assign idle_step = sat_step(idle_cnt_reg, IDLE_LIMIT, bus_idle_state);

  //////////////////////////////////////////////////////////////////////////////
  // Bus timers: quiet time before attach, K-state length, long idle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet_cnt_reg <= {QUIET_W{1'b0}};
      kstate_cnt_reg <= {QUIET_W{1'b0}};
      idle_cnt_reg <= {IDLE_W{1'b0}};
      peer_seen_reg <= 1'b0;
    end else begin
      quiet_cnt_reg <= quiet_step[QUIET_W-1:0];
      kstate_cnt_reg <= kstate_step[QUIET_W-1:0];
      idle_cnt_reg <= idle_step;
      // Tracks connection so attach and detach fire once per change.
      if (events[`BIT_ATTACH]) begin
        peer_seen_reg <= 1'b1;
      end else if (host_operation_enable && !peer_present && bus_se0) begin
        peer_seen_reg <= 1'b0;
      end
    end
  end

  assign quiet_done = (quiet_cnt_reg == QUIET_LIMIT);

  //////////////////////////////////////////////////////////////////////////////
  // Event sources, one strobe per flag bit.
  always @* begin
    events = 8'h00;
    events[`BIT_STALL] = stall_event;
    events[`BIT_ATTACH] = host_operation_enable && quiet_done && !bus_se0 && peer_present && !peer_seen_reg;
    events[`BIT_RESUME] = (kstate_cnt_reg == QUIET_LIMIT - 1'b1) && bus_k_state;
    events[`BIT_IDLE] = (idle_cnt_reg == IDLE_LIMIT - 1'b1) && bus_idle_state;
    events[`BIT_TOKEN] = token_done;
    events[`BIT_SOF] = host_operation_enable ? sof_threshold_hit : sof_token_rx;
    events[`BIT_ERROR] = |(error_events & error_interrupt_enable_reg);
    events[`BIT_RESET_DETACH] = host_operation_enable ? (peer_seen_reg && !peer_present && bus_se0) :
      bus_reset_detect;
  end

  always @* begin
    usb_interrupt_flags_next = (usb_interrupt_flags_reg & ~clear_bits) | events;
    // flag survives pop
    // A pop that leaves another result queued keeps the flag up, so software sees every result.
    if (stat_pop_ok && stat_more_after_pop) begin
      usb_interrupt_flags_next[`BIT_TOKEN] = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers written by software and sticky state.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usb_interrupt_flags_reg <= `FLAGS_RESET;
      irq_mask_reg <= `MASK_RESET;
      error_interrupt_enable_reg <= {ERR_WIDTH{1'b0}};
      error_status_reg <= {ERR_WIDTH{1'b0}};
      host_operation_enable <= 1'b0;
      irq <= 1'b0;
    end else begin
      usb_interrupt_flags_reg <= usb_interrupt_flags_next;
      if (wr_access && paddr == `OFS_IRQ_MASK) begin
        irq_mask_reg <= pwdata[7:0];
      end
      if (wr_access && paddr == `OFS_ERR_ENABLE) begin
        error_interrupt_enable_reg <= pwdata[ERR_WIDTH-1:0];
      end
      if (wr_access && paddr == `OFS_CONTROL) begin
        host_operation_enable <= pwdata[`CTRL_HOST_EN];
      end
      // Raw error causes, write one to clear, set wins.
      error_status_reg <= (error_status_reg &
        ~((wr_access && paddr == `OFS_ERR_STATUS) ? pwdata[ERR_WIDTH-1:0] : {ERR_WIDTH{1'b0}})) | error_events;
      // The interrupt is registered from the next flag value, so it rises with the flag that it reports.
      irq <= |(usb_interrupt_flags_next & irq_mask_reg);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // token result queue
  token_status_fifo #(
    .WIDTH(STAT_WIDTH),
    .DEPTH_LOG2(STAT_DEPTH_LOG2)
  ) u_stat (
    .pclk(pclk),
    .presetn(presetn),
    .push(token_done),
    .push_data(token_status),
    .pop(token_pop),
    .head_reg(token_status_reg),
    .empty(stat_empty),
    .full(stat_full)
  );

  // Mirror of the queue fill level; a push and a pop in one cycle leave it unchanged.
  // It follows the queue's own refusal rules, so it can never drift from the real level.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_count_reg <= {(STAT_DEPTH_LOG2+1){1'b0}};
    end else if (stat_push_ok && !stat_pop_ok) begin
      stat_count_reg <= stat_count_reg + 1'b1;
    end else if (stat_pop_ok && !stat_push_ok) begin
      stat_count_reg <= stat_count_reg - 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read mux.
  always @* begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `OFS_FLAGS: rd_mux[7:0] = usb_interrupt_flags_reg;
      `OFS_IRQ_MASK: rd_mux[7:0] = irq_mask_reg;
      `OFS_ERR_ENABLE: rd_mux[ERR_WIDTH-1:0] = error_interrupt_enable_reg;
      `OFS_ERR_STATUS: rd_mux[ERR_WIDTH-1:0] = error_status_reg;
      `OFS_CONTROL: rd_mux[`CTRL_HOST_EN] = host_operation_enable;
      `OFS_TOKEN_STATUS: rd_mux[STAT_WIDTH+1:0] = {stat_full, stat_empty, token_status_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Zero-wait answer: pready rises in the first access cycle; unmapped addresses error.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped(paddr);
      if (psel && !penable && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end
endmodule

// [hdl/usb_flags_defines.vh]
// Constants for the USB interrupt flag block: offsets, bit positions, resets and timings.
`ifndef USB_FLAGS_DEFINES_VH
`define USB_FLAGS_DEFINES_VH
`define OFS_FLAGS 12'h000
`define OFS_IRQ_MASK 12'h004
`define OFS_ERR_ENABLE 12'h008
`define OFS_ERR_STATUS 12'h00c
`define OFS_CONTROL 12'h010
`define OFS_TOKEN_STATUS 12'h014
`define BIT_STALL 7
`define BIT_ATTACH 6
`define BIT_RESUME 5
`define BIT_IDLE 4
`define BIT_TOKEN 3
`define BIT_SOF 2
`define BIT_ERROR 1
`define BIT_RESET_DETACH 0
`define CTRL_HOST_EN 0
`define FLAGS_RESET 8'h00
`define MASK_RESET 8'h00
`define CLK_PERIOD_NS 10
`define QUIET_TIME_NS 2500
`define QUIET_CYCLES ((`QUIET_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define IDLE_TIME_NS 3000000
`define IDLE_CYCLES_DEFAULT ((`IDLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// [hdl/token_status_fifo.v]
// Small queue of token results; the head comes out of a register.
`timescale 1ns/1ps
module token_status_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH_LOG2 = 2
) (
  input wire pclk,
  input wire presetn,
  input wire push,
  input wire [WIDTH-1:0] push_data,
  input wire pop,
  output reg [WIDTH-1:0] head_reg,
  output wire empty,
  output wire full
);
  localparam DEPTH = 1 << DEPTH_LOG2;
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [DEPTH_LOG2:0] wr_ptr_reg;
  reg [DEPTH_LOG2:0] rd_ptr_reg;
  wire do_push;
  wire do_pop;
  wire [DEPTH_LOG2:0] rd_next;

  // Full when pointers differ only in the wrap bit; a push into a full queue is dropped.
  assign empty = (wr_ptr_reg == rd_ptr_reg);
  assign full = (wr_ptr_reg[DEPTH_LOG2-1:0] == rd_ptr_reg[DEPTH_LOG2-1:0]) && !empty;
  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  assign rd_next = do_pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;

  // Storage has no reset so it maps onto plain memory.
  always @(posedge pclk) begin
    if (do_push) begin
      mem[wr_ptr_reg[DEPTH_LOG2-1:0]] <= push_data;
    end
  end

  // Pointers and registered head; a push into an empty queue bypasses to the head.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_reg <= {(DEPTH_LOG2+1){1'b0}};
      rd_ptr_reg <= {(DEPTH_LOG2+1){1'b0}};
      head_reg <= {WIDTH{1'b0}};
    end else begin
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      rd_ptr_reg <= rd_next;
      if (do_push && (rd_next == wr_ptr_reg)) begin
        head_reg <= push_data;
      end else if (rd_next != wr_ptr_reg) begin
        head_reg <= mem[rd_next[DEPTH_LOG2-1:0]];
      end
    end
  end
endmodule

// [tb/usb_flags_assertions.sv]
// Checker for the flag block's APB slave, mode bit and interrupt output.
`timescale 1ns/1ps
module usb_flags_assertions (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire irq,
  input wire host_operation_enable
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Completed transfers and control writes are decoded once here.
  wire acc = psel && penable && pready;
  wire ctl_wr = acc && pwrite && paddr == 12'h010;
  property p_zero_wait; psel && !penable |=> pready; endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("no answer after setup");
  property p_one_cycle; pready |=> !pready; endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("ready held too long");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_upper; acc && !pwrite && paddr == 12'h000 |-> prdata[31:8] == 24'h000000; endproperty
  a_upper: assert property (p_upper) else $error("flag upper bits set");
  property p_unmapped; acc && paddr > 12'h014 |-> pslverr && (pwrite || prdata == 32'h0); endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
  property p_mode_wr; ctl_wr |=> host_operation_enable == $past(pwdata[0]); endproperty
  a_mode_wr: assert property (p_mode_wr) else $error("mode bit not written");
  property p_mode_hold; !ctl_wr |=> $stable(host_operation_enable); endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode bit changed alone");
  property p_mask_off; acc && pwrite && paddr == 12'h004 && pwdata[7:0] == 8'h00 |-> ##2 !irq; endproperty
  a_mask_off: assert property (p_mask_off) else $error("interrupt with all masked");
endmodule

// [tb/usb_bus_peer.sv]
// Model of the USB bus peer driving event pulses and line states.
`timescale 1ns/1ps
module usb_bus_peer (
  input wire pclk,
  output reg stall_event,
  output reg bus_activity,
  output reg bus_se0,
  output reg bus_k_state,
  output reg bus_idle_state,
  output reg peer_present,
  output reg token_done,
  output reg [7:0] token_status,
  output reg sof_token_rx,
  output reg sof_threshold_hit,
  output reg [7:0] error_events,
  output reg bus_reset_detect
);
  // The bus starts busy, so no quiet or idle timer can run before it is asked.
  initial begin
    {stall_event, token_done, sof_token_rx, sof_threshold_hit, bus_reset_detect} = 5'h00;
    {bus_activity, bus_se0, bus_k_state, bus_idle_state, peer_present} = 5'h10;
    error_events = 8'h00;
    token_status = 8'h00;
  end
  // Line levels change together just after an edge.
  task lines(input [4:0] v);
    begin
      @(posedge pclk);
      {bus_activity, bus_se0, bus_k_state, bus_idle_state, peer_present} <= v;
    end
  endtask
  // one-cycle event pulses
  // Status data is inverted after its pulse so a late sample cannot pass.
  task fire(input [3:0] k, input [7:0] d);
    begin
      @(posedge pclk);
      case (k)
        4'h0: stall_event <= 1'b1;
        4'h1: token_done <= 1'b1;
        4'h2: sof_token_rx <= 1'b1;
        4'h3: sof_threshold_hit <= 1'b1;
        4'h4: error_events <= d;
        default: bus_reset_detect <= 1'b1;
      endcase
      token_status <= d;
      @(posedge pclk);
      {stall_event, token_done, sof_token_rx, sof_threshold_hit, bus_reset_detect} <= 5'h00;
      error_events <= 8'h00;
      token_status <= ~d;
    end
  endtask
endmodule

// [tb/tb.sv]
// Self-checking bench for the USB interrupt flag block.
`timescale 1ns/1ps
module tb;
  reg pclk = 1'b0;
  reg presetn;
  reg psel;
  reg penable;
  reg pwrite;
  reg [11:0] paddr;
  reg [31:0] pwdata;
  reg [31:0] r;
  reg [15:0] rows [0:9];
  integer i, cycles = 0, miscompares = 0, comparisons = 0;
  wire [31:0] prdata;
  wire pready, pslverr, irq, host_operation_enable;
  wire stall_event, bus_activity, bus_se0, bus_k_state, bus_idle_state, peer_present;
  wire token_done, sof_token_rx, sof_threshold_hit, bus_reset_detect;
  wire [7:0] token_status, error_events;
  usb_interrupt_flag_register #(.IDLE_CYCLES(50)) usb_interrupt_flag_register_inst (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .host_operation_enable, .stall_event,
    .bus_activity, .bus_se0, .bus_k_state, .bus_idle_state, .peer_present, .token_done, .token_status,
    .sof_token_rx, .sof_threshold_hit, .error_events, .bus_reset_detect);
  usb_bus_peer usb_bus_peer_inst (.pclk, .stall_event, .bus_activity, .bus_se0, .bus_k_state, .bus_idle_state,
    .peer_present, .token_done, .token_status, .sof_token_rx, .sof_threshold_hit, .error_events, .bus_reset_detect);
  always #5 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////
  // APB master: holds the request until ready is sampled, with no wait limit of its own.
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // Wait states are up to the slave; only the bench timeout ends a hang.
      while (pready !== 1'b1) begin
        @(posedge pclk);
      end
      r = prdata;
      {psel, penable} <= 2'b00;
    end
  endtask
  task check(input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("mismatch at %0t: saw %h wanted %h", $time, seen, exp);
      end
    end
  endtask
  task rdc(input [11:0] a, input [31:0] exp);
    begin
      apb(1'b0, a, 32'h0);
      check(r, exp);
    end
  endtask
  task finish_test;
    begin
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // A hang counts as a mismatch and still reaches the closing report.
  always @(posedge pclk) begin
    cycles = cycles + 1;
    if (cycles == 6000) begin
      miscompares = miscompares + 1;
      finish_test;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Rows: host mode in bit 12, event kind in 11:8, expected flags in 7:0.
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} <= {4'h0, 12'h000, 32'h00000000};
    rows = '{16'h0080, 16'h1080, 16'h0108, 16'h0204, 16'h1200, 16'h1304, 16'h0300, 16'h0402, 16'h0501, 16'h1500};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdc(12'h000, 32'h0);
    rdc(12'h020, 32'h0);
    apb(1'b1, 12'h008, 32'hff);
    for (i = 0; i < 10; i = i + 1) begin
      apb(1'b1, 12'h010, {28'h0, rows[i][15:12]});
      usb_bus_peer_inst.fire(rows[i][11:8], 8'hff);
      rdc(12'h000, {24'h0, rows[i][7:0]});
      apb(1'b1, 12'h000, 32'h0);
      rdc(12'h000, {24'h0, rows[i][7:0]});
      apb(1'b1, 12'h000, 32'hff);
      rdc(12'h000, 32'h0);
    end
    // Only error source 0 is enabled, so source 1 must be ignored.
    apb(1'b1, 12'h008, 32'h01);
    usb_bus_peer_inst.fire(4'h4, 8'h02);
    rdc(12'h000, 32'h0);
    usb_bus_peer_inst.fire(4'h4, 8'h01);
    rdc(12'h000, 32'h02);
    apb(1'b1, 12'h004, 32'h02);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, 12'h000, 32'hff);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    // Quiet bus with a peer present attaches only in host mode.
    apb(1'b1, 12'h010, 32'h0);
    usb_bus_peer_inst.lines(5'h01);
    repeat (260) @(posedge pclk);
    rdc(12'h000, 32'h0);
    apb(1'b1, 12'h010, 32'h1);
    repeat (260) @(posedge pclk);
    rdc(12'h000, 32'h40);
    apb(1'b1, 12'h000, 32'hff);
    usb_bus_peer_inst.lines(5'h08);
    repeat (5) @(posedge pclk);
    rdc(12'h000, 32'h01);
    apb(1'b1, 12'h000, 32'hff);
    // K-state must last the full quiet time before resume shows.
    usb_bus_peer_inst.lines(5'h04);
    repeat (240) @(posedge pclk);
    rdc(12'h000, 32'h0);
    repeat (20) @(posedge pclk);
    rdc(12'h000, 32'h20);
    apb(1'b1, 12'h000, 32'hff);
    usb_bus_peer_inst.lines(5'h02);
    repeat (60) @(posedge pclk);
    rdc(12'h000, 32'h10);
    apb(1'b1, 12'h000, 32'hff);
    // Two queued token results come out in order as the flag is cleared.
    usb_bus_peer_inst.lines(5'h10);
    apb(1'b1, 12'h010, 32'h0);
    usb_bus_peer_inst.fire(4'h1, 8'h5a);
    usb_bus_peer_inst.fire(4'h1, 8'ha5);
    rdc(12'h014, 32'h5a);
    apb(1'b1, 12'h000, 32'h08);
    rdc(12'h014, 32'ha5);
    rdc(12'h000, 32'h08);
    // Reset in mid-run drops the flags, the queue and the mode bit.
    apb(1'b1, 12'h010, 32'h1);
    usb_bus_peer_inst.fire(4'h0, 8'h00);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(12'h000, 32'h0);
    rdc(12'h014, 32'h100);
    rdc(12'h010, 32'h0);
    finish_test;
  end
endmodule
bind usb_interrupt_flag_register usb_flags_assertions chk_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .irq, .host_operation_enable);
